// ---- rtl/lpr_timer_pkg.sv ----
// Summary of operation
// - Delay select low picks 7.5 s, high picks 11.25 s.
// - Delay is counted from prescaled oscillator ticks (one per 256 clocks) in a two-stage 21-bit counter.
// - Counting runs only while both button inputs are low.
// - Either button returning high stops counting and clears the count.
// - Release before the delay leaves both reset outputs inactive.
// - Count past the delay pulls the open-drain reset output low.
// - Count past the delay drives the push-pull reset output high.
// - After asserting, counting stops; outputs hold while both inputs stay low.
// - Either input high after assertion clears timer and deasserts outputs.
// - Inactive: open-drain released high, push-pull low.
`default_nettype none

package lpr_timer_pkg;

    // ------------------------------------------------------------------
    // Timing constants
    // ------------------------------------------------------------------
    localparam longint unsigned CLK_HZ         = 64'd40_000_000;
    localparam longint unsigned SHORT_DELAY_MS = 64'd7_500;
    localparam longint unsigned LONG_DELAY_MS  = 64'd11_250;
    localparam int unsigned     CNT_BITS       = 21;
    localparam int unsigned     LOW_BITS       = 10;
    localparam int unsigned     HIGH_BITS      = CNT_BITS - LOW_BITS;
    // Prescaler width; it only has to hold the largest divide ratio.
    localparam int unsigned     DIV_BITS       = 16;
    // Oscillator clocks per counter step; counter steps are the prescaler ticks.
    localparam longint unsigned TICK_DIV       = 64'd256;
    localparam longint unsigned SHORT_STEPS    = SHORT_DELAY_MS * CLK_HZ / 64'd1000 / TICK_DIV;
    localparam longint unsigned LONG_STEPS     = LONG_DELAY_MS * CLK_HZ / 64'd1000 / TICK_DIV;

    typedef enum logic [1:0] {IDLE, COUNTING, ASSERTED} timer_state_t;

endpackage

`default_nettype wire

// ---- rtl/pin_sync.sv ----
`default_nettype none

// ----------------------------------------------------------------------
// Three-stage pin synchroniser with agreement filter
// ----------------------------------------------------------------------
module pin_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic pinIn,
    output logic      pinOut
);

    logic [2:0] stage_q;
    logic [2:0] stage_d;
    logic       out_q;
    logic       out_d;

    // Stage 0 feeds only stage 1; stages 1 and 2 must agree before a change counts.
    always_comb
    begin
        stage_d = {stage_q[1:0], pinIn};
        out_d   = (stage_q[2] == stage_q[1]) ? stage_q[2] : out_q;
    end

    // Register the chain.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            stage_q <= {3{RESET_VAL}};
            out_q   <= RESET_VAL;
        end
        else
        begin
            stage_q <= stage_d;
            out_q   <= out_d;
        end
    end

    assign pinOut = out_q;

endmodule

`default_nettype wire

// ---- rtl/long_press_reset_timer.sv ----
`default_nettype none

// ----------------------------------------------------------------------
// Long-press reset timer
// ----------------------------------------------------------------------
module long_press_reset_timer
    import lpr_timer_pkg::*;
#(
    parameter longint unsigned SHORT_STEP_COUNT = lpr_timer_pkg::SHORT_STEPS,
    parameter longint unsigned LONG_STEP_COUNT  = lpr_timer_pkg::LONG_STEPS,
    parameter longint unsigned TICK_DIVIDE      = lpr_timer_pkg::TICK_DIV
) (
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic primary_button_n,
    input  wire logic secondary_button_n,
    input  wire logic delay_select,
    input  wire logic scan_test_pin,
    output logic      od_reset_out_n,
    output logic      od_reset_oe,
    output logic      pp_reset_out
);

    localparam logic [CNT_BITS-1:0] SHORT_TC = SHORT_STEP_COUNT[CNT_BITS-1:0];
    localparam logic [CNT_BITS-1:0] LONG_TC  = LONG_STEP_COUNT[CNT_BITS-1:0];
    localparam logic [DIV_BITS-1:0] DIV_TC   = DIV_BITS'(TICK_DIVIDE - 64'd1);

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic btnPrimN;
    logic btnSecN;
    logic selSync;

    pin_sync #(.RESET_VAL(1'b1)) u_sync_prim (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .pinIn   (primary_button_n),
        .pinOut  (btnPrimN)
    );

    pin_sync #(.RESET_VAL(1'b1)) u_sync_sec (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .pinIn   (secondary_button_n),
        .pinOut  (btnSecN)
    );

    pin_sync #(.RESET_VAL(1'b0)) u_sync_sel (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .pinIn   (delay_select),
        .pinOut  (selSync)
    );

    // The scan pin only steers test logic outside this block; it is held low.
    logic scanUnused;
    assign scanUnused = scan_test_pin;

    // ------------------------------------------------------------------
    // Timer state
    // ------------------------------------------------------------------
    timer_state_t          state_q,   state_d;
    logic [DIV_BITS-1:0]   div_q,     div_d;
    logic [LOW_BITS-1:0]   cntLow_q,  cntLow_d;
    logic [HIGH_BITS-1:0]  cntHigh_q, cntHigh_d;
    logic                  selLong_q, selLong_d;
    logic                  odOe_q,    odOe_d;
    logic                  odVal_q,   odVal_d;
    logic                  pp_q,      pp_d;
    logic                  bothLow;
    logic                  countEn;
    logic                  tick;
    logic                  lowWrap;
    logic                  termHit;
    logic [CNT_BITS-1:0]   count;
    logic [CNT_BITS-1:0]   termCount;

    // Shared decodes. A single low button never reaches the counter.
    assign bothLow   = !btnPrimN && !btnSecN;
    assign countEn   = (state_q == COUNTING) && bothLow;
    assign tick      = (div_q == DIV_TC);
    assign count     = {cntHigh_q, cntLow_q};
    assign lowWrap   = &cntLow_q;
    assign termCount = selLong_q ? LONG_TC : SHORT_TC;
    assign termHit   = (count >= termCount);

    // ------------------------------------------------------------------
    // Oscillator prescaler
    // ------------------------------------------------------------------

    // The prescaler only runs during a timed press; idle or asserted, it is
    // parked at zero so that the next press always starts on a full period.
    always_comb
    begin
        div_d = '0;
        if (countEn && !tick)
        begin
            div_d = div_q + 1'b1;
        end
    end

    // Register the prescaler.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            div_q <= '0;
        end
        else
        begin
            div_q <= div_d;
        end
    end

    // ------------------------------------------------------------------
    // Two-stage step counter
    // ------------------------------------------------------------------

    // The low stage steps on each prescaler tick and carries into the high
    // stage when it wraps. Stepping stops at the terminal value, so an
    // asserted timer holds a steady count until a button is let go.
    always_comb
    begin
        cntLow_d  = cntLow_q;
        cntHigh_d = cntHigh_q;
        if (!bothLow)
        begin
            // Either button up: the next press starts from zero.
            cntLow_d  = '0;
            cntHigh_d = '0;
        end
        else if (countEn && tick && !termHit)
        begin
            cntLow_d = cntLow_q + 1'b1;
            if (lowWrap)
            begin
                cntHigh_d = cntHigh_q + 1'b1;
            end
        end
    end

    // Register both counter stages.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            cntLow_q  <= '0;
            cntHigh_q <= '0;
        end
        else
        begin
            cntLow_q  <= cntLow_d;
            cntHigh_q <= cntHigh_d;
        end
    end

    // ------------------------------------------------------------------
    // Press tracking and reset outputs
    // ------------------------------------------------------------------

    // The delay select is captured on the press, not followed, so a strap
    // that moves in mid-press cannot stretch or cut the interval.
    always_comb
    begin
        state_d   = state_q;
        selLong_d = selLong_q;
        odOe_d    = odOe_q;
        odVal_d   = odVal_q;
        pp_d      = pp_q;
        unique case (state_q)
            IDLE:
            begin
                if (bothLow)
                begin
                    state_d   = COUNTING;
                    selLong_d = selSync;
                end
            end
            COUNTING:
            begin
                if (!bothLow)
                begin
                    // Early release: back to idle, outputs never move.
                    state_d = IDLE;
                end
                else if (tick && termHit)
                begin
                    // Count has reached N: assert and stop counting.
                    state_d = ASSERTED;
                    odOe_d  = 1'b1;
                    odVal_d = 1'b0;
                    pp_d    = 1'b1;
                end
            end
            ASSERTED:
            begin
                if (!bothLow)
                begin
                    state_d = IDLE;
                    odOe_d  = 1'b0;
                    odVal_d = 1'b1;
                    pp_d    = 1'b0;
                end
            end
        endcase
    end

    // Register the control state; reset leaves both outputs inactive.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q   <= IDLE;
            selLong_q <= 1'b0;
            odOe_q    <= 1'b0;
            odVal_q   <= 1'b1;
            pp_q      <= 1'b0;
        end
        else
        begin
            state_q   <= state_d;
            selLong_q <= selLong_d;
            odOe_q    <= odOe_d;
            odVal_q   <= odVal_d;
            pp_q      <= pp_d;
        end
    end

    // Open-drain pin: the value is low whenever the enable is high, so the
    // pin can only ever pull down; the host's pull-up gives the high level.
    assign od_reset_out_n = odVal_q;
    assign od_reset_oe    = odOe_q;
    assign pp_reset_out   = pp_q;

endmodule

`default_nettype wire

// ---- sim/lpr_timer_chk.sv ----
`default_nettype none
// ------------------------------------------------------------
// Port checker for the long-press reset timer
// ------------------------------------------------------------
module lpr_timer_chk #(
    parameter longint unsigned SHORT_STEP_COUNT = 5,
    parameter longint unsigned LONG_STEP_COUNT  = 8,
    parameter longint unsigned TICK_DIVIDE      = 2
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic primary_button_n,
    input wire logic secondary_button_n,
    input wire logic delay_select,
    input wire logic scan_test_pin,
    input wire logic od_reset_out_n,
    input wire logic od_reset_oe,
    input wire logic pp_reset_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned lowCnt_q, lowCnt_d, tc;
    logic        selQ_q, selQ_d;
    // Cycles both buttons have been low, and the select seen at the press.
    always_comb
    begin
        lowCnt_d = (primary_button_n || secondary_button_n) ? 0 : lowCnt_q + 1;
        selQ_d   = (lowCnt_q == 0) ? delay_select : selQ_q;
    end
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            lowCnt_q <= 0;
            selQ_q   <= 1'b0;
        end
        else
        begin
            lowCnt_q <= lowCnt_d;
            selQ_q   <= selQ_d;
        end
    end
    // Terminal step count; the sync delay is absorbed by a small slack.
    assign tc = selQ_q ? int'(LONG_STEP_COUNT) : int'(SHORT_STEP_COUNT);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence s_released; (primary_button_n || secondary_button_n) [*6]; endsequence
    property p_pair; pp_reset_out == od_reset_oe; endproperty
    property p_odLow; od_reset_oe |-> !od_reset_out_n; endproperty
    property p_early; $rose(od_reset_oe) |-> lowCnt_q >= tc * TICK_DIVIDE + 2; endproperty
    property p_late; lowCnt_q == tc * TICK_DIVIDE + 8 |-> od_reset_oe; endproperty
    property p_hold; od_reset_oe && lowCnt_q > 8 |=> od_reset_oe; endproperty
    property p_drop; s_released |-> !od_reset_oe && !pp_reset_out; endproperty
    property p_fell; $fell(od_reset_oe) |-> lowCnt_q < 6; endproperty
    property p_both; $rose(pp_reset_out) |-> !primary_button_n && !secondary_button_n; endproperty
    a_pair: assert property (p_pair) else $error("reset outputs disagree");
    a_odLow: assert property (p_odLow) else $error("open-drain value high");
    a_early: assert property (p_early) else $error("reset too early");
    a_late: assert property (p_late) else $error("reset too late");
    a_hold: assert property (p_hold) else $error("reset dropped while held");
    a_drop: assert property (p_drop) else $error("reset active after release");
    a_fell: assert property (p_fell) else $error("reset fell while held");
    a_both: assert property (p_both) else $error("reset with one button");
endmodule
bind long_press_reset_timer lpr_timer_chk #(.SHORT_STEP_COUNT(SHORT_STEP_COUNT),
    .LONG_STEP_COUNT(LONG_STEP_COUNT), .TICK_DIVIDE(TICK_DIVIDE)) lpr_timer_chk_i (
    .clk_sys(clk_sys), .resetn(resetn), .primary_button_n(primary_button_n),
    .secondary_button_n(secondary_button_n), .delay_select(delay_select),
    .scan_test_pin(scan_test_pin), .od_reset_out_n(od_reset_out_n),
    .od_reset_oe(od_reset_oe), .pp_reset_out(pp_reset_out));
`default_nettype wire

// ---- sim/host_reset_model.sv ----
`default_nettype none
// ------------------------------------------------------------
// Host side: pulled-up reset line and strapped test pin
// ------------------------------------------------------------
module host_reset_model (
    input  wire logic odOut,
    input  wire logic odEn,
    output logic      odWire,
    output logic      scanTest
);
    timeunit 1ns;
    timeprecision 1ps;
    // The pull-up wins whenever the pin is released.
    assign odWire   = odEn ? odOut : 1'b1;
    assign scanTest = 1'b0;
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
`default_nettype none
// ------------------------------------------------------------
// Bench top
// ------------------------------------------------------------
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, resetn = 0, pBtnN = 1, sBtnN = 1, sel = 0;
    logic odN, oe, pp, odWire, scanTest;
    int   error_cnt = 0, comparisons = 0, n;
    always #12.5 clk_sys = ~clk_sys;
    // Short counts keep each timed press to a few dozen cycles.
    long_press_reset_timer #(.SHORT_STEP_COUNT(5), .LONG_STEP_COUNT(8), .TICK_DIVIDE(2))
        long_press_reset_timer_i (.clk_sys(clk_sys), .resetn(resetn), .primary_button_n(pBtnN),
        .secondary_button_n(sBtnN), .delay_select(sel), .scan_test_pin(scanTest),
        .od_reset_out_n(odN), .od_reset_oe(oe), .pp_reset_out(pp));
    host_reset_model host_reset_model_i (.odOut(odN), .odEn(oe), .odWire(odWire),
        .scanTest(scanTest));
    task automatic chk(logic got, logic exp, string what);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Buttons change just after an edge, then outputs are watched.
    task automatic press_idle(logic p, logic s, int cycles);
        @(posedge clk_sys);
        pBtnN <= p;
        sBtnN <= s;
        repeat (cycles)
        begin
            @(posedge clk_sys);
            #1 chk(odWire, 1'b1, "line pulled low");
            chk(pp, 1'b0, "push-pull high");
        end
    endtask
    task automatic test_idle;
        press_idle(1, 1, 6);
        press_idle(0, 1, 40);
        press_idle(1, 0, 40);
        press_idle(0, 0, 8);
        press_idle(1, 1, 6);
        $display("idle and short presses done");
    endtask
    // Sel is flipped mid-count when asked; the captured level must win.
    task automatic test_long(logic s, int lo, int hi, logic flip);
        @(posedge clk_sys);
        sel <= s;
        press_idle(0, 0, 0);
        n = 0;
        while (oe !== 1'b1 && n < 60)
        begin
            @(posedge clk_sys);
            n++;
            if (n == 8 && flip) sel <= ~s;
            #1;
        end
        if (n >= 60)
        begin
            error_cnt++;
            tally_and_finish;
        end
        chk(n >= lo && n <= hi, 1'b1, "delay out of window");
        chk(pp, 1'b1, "push-pull not asserted");
        chk(odWire, 1'b0, "line not pulled low");
        repeat (30) @(posedge clk_sys);
        #1 chk(oe, 1'b1, "reset not held");
        // The release needs the input filter's latency before the outputs drop.
        @(posedge clk_sys);
        pBtnN <= 1'b1;
        n = 0;
        while (oe !== 1'b0 && n < 8)
        begin
            @(posedge clk_sys);
            n++;
            #1;
        end
        chk(n >= 4 && n <= 6, 1'b1, "release not seen in time");
        chk(pp, 1'b0, "push-pull still high");
        press_idle(1, 0, 8);
        $display("long press sel %0d done", s);
    endtask
    // A reset in mid-press drops both outputs at once; the held press is then re-timed.
    task automatic test_reset;
        press_idle(0, 0, 0);
        repeat (24) @(posedge clk_sys);
        #1 chk(oe, 1'b1, "output not asserted before reset");
        @(posedge clk_sys);
        resetn <= 1'b0;
        #1 chk(odWire, 1'b1, "line low in reset");
        chk(pp, 1'b0, "push-pull high in reset");
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        press_idle(0, 0, 6);
        press_idle(1, 1, 8);
        $display("reset during press done");
    endtask
    initial
    begin
        repeat (4) @(posedge clk_sys);
        resetn <= 1;
        test_idle;
        test_long(1'b0, 12, 18, 1'b0);
        test_long(1'b1, 18, 24, 1'b1);
        test_reset;
        tally_and_finish;
    end
endmodule
`default_nettype wire
